// file: verilog/wpr_ctrl.sv
// Purpose: power control register, watchdog timer and reset conditioning
// Assumes: ref_clk is the oscillator, registers reached over ahb-lite
// Notes:   one clock; slower rates are enables
// Operation
// - cold boot flag set at power-on only
// - two user flags only store written values
// - power-down stops all clocks until reset
// - idle stops processor clock, peripherals keep running
// - idle ends on interrupt or reset
// - any reset disables and clears watchdog
// - enable bit starts and stops counting
// - restart bit clears counter, prescaler, itself
// - sleep enable keeps watchdog running in idle
// - select field picks prescale from two to 256
// - timeout after 12 times 2^14 times prescale
// - timeout while enabled causes system reset
// - oscillator clock divided by two internally
// - reset sampled at state5_phase2_sample_point, two cycles held
// - short glitches on reset line ignored
// - reset loads ports, stack, clears registers except interrupt status, mask and cold boot flag
`timescale 1ns/10ps
module wpr_ctrl
  import wpr_pkg::*;
#(
  parameter int WDOG_BITS = 14,
  parameter int PS_BITS   = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        reset_pin,
  input  wire logic        irq_pending,
  output wpr_pm_t          pm_out,
  output wpr_init_t        init_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // clock divider and machine cycle
  // ----------------------------------------------------------------
  logic                         half_q;
  logic [2:0]                   state_q;
  logic                         state_end;
  logic                         mc_tick;
  logic                         sample_pt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  assign state_end = half_q;
  assign mc_tick   = state_end && (state_q == 3'(STATES_PER_MC - 1));
  assign sample_pt = state_end && (state_q == SAMPLE_STATE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= 3'h0;
    end else if (mc_tick) begin
      state_q <= 3'h0;
    end else if (state_end) begin
      state_q <= state_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // reset pin synchroniser, sampling and filter
  // ----------------------------------------------------------------
  logic                         pin_s1_q;
  logic                         pin_s2_q;
  logic [1:0]                   hi_cnt_q;
  logic                         ext_rst;
  logic                         ext_rst_rise;
  logic                         ext_rst_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= reset_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // sample at state five phase two
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= 2'h0;
    end else if (sample_pt) begin
      if (!pin_s2_q) begin
        hi_cnt_q <= 2'h0;
      end else if (hi_cnt_q != RST_HOLD_MC) begin
        hi_cnt_q <= hi_cnt_q + 2'h1;
      end
    end
  end

  assign ext_rst      = (hi_cnt_q == RST_HOLD_MC);
  assign ext_rst_rise = ext_rst && !ext_rst_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_rst_q <= 1'b0;
    end else begin
      ext_rst_q <= ext_rst;
    end
  end

  // ----------------------------------------------------------------
  // internal reset state machine
  // ----------------------------------------------------------------
  wpr_rst_state_t               rs_q;
  wpr_rst_state_t               rs_d;
  logic [1:0]                   wrst_cnt_q;
  logic                         wdog_timeout;
  logic                         sys_rst;

  always_comb begin
    rs_d = rs_q;
    case (rs_q)
      WPR_RS_RUN: begin
        if (ext_rst) begin
          rs_d = WPR_RS_EXT;
        end else if (wdog_timeout) begin
          rs_d = WPR_RS_WDOG;
        end
      end
      WPR_RS_EXT: begin
        if (!ext_rst) begin
          rs_d = WPR_RS_RUN;
        end
      end
      WPR_RS_WDOG: begin
        if (ext_rst) begin
          rs_d = WPR_RS_EXT;
        end else if (mc_tick && (wrst_cnt_q == WDOG_RST_MC - 2'h1)) begin
          rs_d = WPR_RS_RUN;
        end
      end
      default: begin
        rs_d = WPR_RS_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rs_q       <= WPR_RS_RUN;
      wrst_cnt_q <= 2'h0;
    end else begin
      rs_q <= rs_d;
      if (rs_q != WPR_RS_WDOG) begin
        wrst_cnt_q <= 2'h0;
      end else if (mc_tick) begin
        wrst_cnt_q <= wrst_cnt_q + 2'h1;
      end
    end
  end

  // one reset path for both sources
  assign sys_rst = (rs_q != WPR_RS_RUN);

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic                         wr_pend_q;
  logic [31:0]                  wr_addr_q;
  logic                         addr_ok;
  logic                         rd_take;
  logic                         wr_pwr;
  logic                         wr_wdog;
  logic                         wr_stat;
  logic                         wr_mask;
  logic [31:0]                  rd_word;

  assign addr_ok   = hsel && htrans[1] && hready;
  assign rd_take   = addr_ok && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_pwr    = wr_pend_q && (wr_addr_q == PWR_CTRL_ADDR);
  assign wr_wdog   = wr_pend_q && (wr_addr_q == WDOG_CTRL_ADDR);
  assign wr_stat   = wr_pend_q && (wr_addr_q == IRQ_STAT_ADDR);
  assign wr_mask   = wr_pend_q && (wr_addr_q == IRQ_MASK_ADDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= {haddr[31:2], 2'b00};
      end
    end
  end

  // ----------------------------------------------------------------
  // power control register
  // ----------------------------------------------------------------
  logic                         cold_q;
  logic [1:0]                   uflag_q;
  logic                         pd_q;
  logic                         idl_q;
  logic                         wake;

  assign wake = idl_q && irq_pending;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cold_q <= 1'b1;
    end else if (wr_pwr) begin
      cold_q <= cold_q & hwdata[PC_COLD_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uflag_q <= PWR_CTRL_RST[PC_UF_HI_BIT:PC_UF_LO_BIT];
      pd_q    <= PWR_CTRL_RST[PC_PD_BIT];
      idl_q   <= PWR_CTRL_RST[PC_IDL_BIT];
    end else if (sys_rst) begin
      uflag_q <= PWR_CTRL_RST[PC_UF_HI_BIT:PC_UF_LO_BIT];
      pd_q    <= PWR_CTRL_RST[PC_PD_BIT];
      idl_q   <= PWR_CTRL_RST[PC_IDL_BIT];
    end else begin
      if (wr_pwr) begin
        uflag_q <= hwdata[PC_UF_HI_BIT:PC_UF_LO_BIT];
      end
      if (wr_pwr && !pd_q) begin
        pd_q <= hwdata[PC_PD_BIT];
      end
      if (wake) begin
        idl_q <= 1'b0;
      end else if (wr_pwr) begin
        idl_q <= hwdata[PC_IDL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog control register and counters
  // ----------------------------------------------------------------
  logic                         wd_en_q;
  logic                         wd_rst_q;
  logic                         wd_slp_q;
  logic [2:0]                   wd_ps_q;
  logic [PS_BITS-1:0]           pre_q;
  logic [WDOG_BITS-1:0]         cnt_q;
  logic                         run;
  logic                         pre_end;
  logic [PS_BITS-1:0]           pre_last;

  function automatic logic [PS_BITS-1:0] ps_last(input logic [2:0] sel);
    logic [3:0] e;
    e = 4'h1;
    case (sel)
      3'b000: e = 4'h1;
      3'b010: e = 4'h2;
      3'b001: e = 4'h3;
      3'b011: e = 4'h4;
      3'b100: e = 4'h5;
      3'b101: e = 4'h6;
      3'b110: e = 4'h7;
      default: e = 4'h8;
    endcase
    return PS_BITS'((32'h0000_0001 << e) - 32'h0000_0001);
  endfunction

  assign pre_last = ps_last(wd_ps_q);
  assign pre_end  = (pre_q == pre_last);

  // hold in power-down and gated idle
  assign run = wd_en_q && !pd_q && (!idl_q || wd_slp_q) && !sys_rst;

  // 12 oscillator periods times prescale per step, 2^14 steps
  assign wdog_timeout = run && mc_tick && pre_end && (&cnt_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_en_q  <= WDOG_CTRL_RST[WD_EN_BIT];
      wd_rst_q <= WDOG_CTRL_RST[WD_RST_BIT];
      wd_slp_q <= WDOG_CTRL_RST[WD_SLP_BIT];
      wd_ps_q  <= WDOG_CTRL_RST[WD_PS_MSB:0];
    end else if (sys_rst) begin
      wd_en_q  <= WDOG_CTRL_RST[WD_EN_BIT];
      wd_rst_q <= WDOG_CTRL_RST[WD_RST_BIT];
      wd_slp_q <= WDOG_CTRL_RST[WD_SLP_BIT];
      wd_ps_q  <= WDOG_CTRL_RST[WD_PS_MSB:0];
    end else begin
      if (wr_wdog) begin
        wd_en_q  <= hwdata[WD_EN_BIT];
        wd_slp_q <= hwdata[WD_SLP_BIT];
        wd_ps_q  <= hwdata[WD_PS_MSB:0];
      end
      if (wr_wdog && hwdata[WD_RST_BIT]) begin
        wd_rst_q <= 1'b1;
      end else if (mc_tick) begin
        wd_rst_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (sys_rst || (wd_rst_q && mc_tick)) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (run && mc_tick) begin
      if (pre_end) begin
        pre_q <= '0;
        cnt_q <= cnt_q + 1'b1;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0]             stat_q;
  logic [IRQ_W-1:0]             mask_q;
  logic [IRQ_W-1:0]             ev;

  assign ev[IRQ_WDOG_BIT] = wdog_timeout;
  assign ev[IRQ_EXT_BIT]  = ext_rst_rise;
  assign ev[IRQ_WAKE_BIT] = wake;

  // set wins over write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
      mask_q <= IRQ_MASK_RST;
    end else begin
      if (wr_stat) begin
        stat_q <= (stat_q & ~hwdata[IRQ_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (wr_mask) begin
        mask_q <= hwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0]                  rdata_q;
  logic [31:0]                  haddr_w;

  assign haddr_w = {haddr[31:2], 2'b00};

  always_comb begin
    if (haddr_w == PWR_CTRL_ADDR) begin
      rd_word = {27'h000_0000, cold_q, uflag_q, pd_q, idl_q};
    end else if (haddr_w == WDOG_CTRL_ADDR) begin
      rd_word = {24'h00_0000, wd_en_q, wd_rst_q, wd_slp_q, 2'b00, wd_ps_q};
    end else if (haddr_w == IRQ_STAT_ADDR) begin
      rd_word = {29'h0000_0000, stat_q};
    end else if (haddr_w == IRQ_MASK_ADDR) begin
      rd_word = {29'h0000_0000, mask_q};
    end else if (haddr_w == WDOG_CNT_ADDR) begin
      rd_word = 32'({pre_q, cnt_q});
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rd_word;
    end
  end

  assign hrdata = rdata_q;

  // ----------------------------------------------------------------
  // clock enables and reset outputs
  // ----------------------------------------------------------------
  wpr_pm_t                      pm_q;
  wpr_init_t                    init_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pm_q   <= '{osc_stop: 1'b0, cpu_clk_en: 1'b0, periph_clk_en: 1'b0, sys_rst: 1'b1};
      init_q <= '{port_val: PORT_RST_VAL, sp_val: SP_RST_VAL};
    end else begin
      // power-down stops oscillator and all enables
      pm_q.osc_stop      <= pd_q && !sys_rst;
      pm_q.cpu_clk_en    <= !state_end && !pd_q && !idl_q && !sys_rst;
      pm_q.periph_clk_en <= !state_end && !pd_q;
      pm_q.sys_rst       <= sys_rst;
      if (sys_rst) begin
        init_q <= '{port_val: PORT_RST_VAL, sp_val: SP_RST_VAL};
      end
    end
  end

  assign pm_out   = pm_q;
  assign init_out = init_q;

endmodule

// file: verilog/wpr_pkg.sv
// Purpose: shared constants and types of the power and watchdog control block
// Assumes: registers indexed by special-function address, byte address is index times four
// Notes:   the timing counts are in oscillator periods or machine cycles
package wpr_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  PWR_CTRL_IDX  = 8'h87;
  localparam logic [7:0]  WDOG_CTRL_IDX = 8'h8F;
  localparam logic [7:0]  IRQ_STAT_IDX  = 8'h90;
  localparam logic [7:0]  IRQ_MASK_IDX  = 8'h91;
  localparam logic [7:0]  WDOG_CNT_IDX  = 8'h92;
  localparam logic [31:0] PWR_CTRL_ADDR  = {22'h00_0000, PWR_CTRL_IDX, 2'b00};
  localparam logic [31:0] WDOG_CTRL_ADDR = {22'h00_0000, WDOG_CTRL_IDX, 2'b00};
  localparam logic [31:0] IRQ_STAT_ADDR  = {22'h00_0000, IRQ_STAT_IDX, 2'b00};
  localparam logic [31:0] IRQ_MASK_ADDR  = {22'h00_0000, IRQ_MASK_IDX, 2'b00};
  localparam logic [31:0] WDOG_CNT_ADDR  = {22'h00_0000, WDOG_CNT_IDX, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PC_COLD_BIT  = 4;
  localparam int PC_UF_HI_BIT = 3;
  localparam int PC_UF_LO_BIT = 2;
  localparam int PC_PD_BIT    = 1;
  localparam int PC_IDL_BIT   = 0;
  localparam int WD_EN_BIT    = 7;
  localparam int WD_RST_BIT   = 6;
  localparam int WD_SLP_BIT   = 5;
  localparam int WD_PS_MSB    = 2;
  localparam int IRQ_WDOG_BIT = 0;
  localparam int IRQ_EXT_BIT  = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_W        = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]       PWR_CTRL_RST  = 8'h00;
  localparam logic [7:0]       WDOG_CTRL_RST = 8'h00;
  localparam logic [7:0]       PORT_RST_VAL  = 8'hFF;
  localparam logic [7:0]       SP_RST_VAL    = 8'h07;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         OSC_PER_MC    = 12;
  localparam int         STATES_PER_MC = OSC_PER_MC / 2;
  localparam logic [2:0] SAMPLE_STATE  = 3'h4;
  localparam logic [1:0] RST_HOLD_MC   = 2'h2;
  localparam logic [1:0] WDOG_RST_MC   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WPR_RS_RUN  = 2'b00,
    WPR_RS_EXT  = 2'b01,
    WPR_RS_WDOG = 2'b10
  } wpr_rst_state_t;

  typedef struct packed {
    logic osc_stop;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic sys_rst;
  } wpr_pm_t;

  typedef struct packed {
    logic [7:0] port_val;
    logic [7:0] sp_val;
  } wpr_init_t;

endpackage

// file: test/wpr_ctrl_asserts.sv
// Purpose: port-level checks of the power and watchdog control block
// Assumes: single clock ref_clk, rst active high
// Notes:   bound to every wpr_ctrl instance
`timescale 1ns/10ps
module wpr_ctrl_asserts
  import wpr_pkg::*;
#(
  parameter int WDOG_BITS = 14,
  parameter int PS_BITS   = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        reset_pin,
  input wire logic        irq_pending,
  input wire wpr_pm_t     pm_out,
  input wire wpr_init_t   init_out,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // pin run-length counters
  // ----------------------------------------------------------------
  logic [6:0] pin_hi_q;
  logic [6:0] pin_lo_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_hi_q <= 7'h00;
      pin_lo_q <= 7'h00;
    end else begin
      pin_hi_q <= !reset_pin ? 7'h00 : (pin_hi_q == 7'h7f ? pin_hi_q : pin_hi_q + 7'h01);
      pin_lo_q <= reset_pin ? 7'h00 : (pin_lo_q == 7'h7f ? pin_lo_q : pin_lo_q + 7'h01);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_div_two_periph: assert property (pm_out.periph_clk_en |=> !pm_out.periph_clk_en)
    else $error("peripheral enable high two cycles in a row");
  a_cpu_in_periph: assert property (pm_out.cpu_clk_en |-> pm_out.periph_clk_en)
    else $error("processor enable outside peripheral enable");
  a_pd_no_clocks: assert property (pm_out.osc_stop ##1 pm_out.osc_stop
    |-> !pm_out.cpu_clk_en && !pm_out.periph_clk_en)
    else $error("clock enable while stopped");
  a_pd_until_reset: assert property (pm_out.osc_stop && !pm_out.sys_rst
    |=> pm_out.osc_stop || pm_out.sys_rst)
    else $error("power-down left without reset");
  a_init_loaded: assert property (pm_out.sys_rst ##1 pm_out.sys_rst
    |-> init_out.port_val == PORT_RST_VAL && init_out.sp_val == SP_RST_VAL)
    else $error("init values wrong during reset");
  a_rst_follows_pin: assert property (pin_hi_q == 7'h30 |-> pm_out.sys_rst)
    else $error("held reset pin gave no reset");
  a_wdog_rst_hold: assert property ($rose(pm_out.sys_rst) && pin_lo_q == 7'h7f
    |-> pm_out.sys_rst [*8])
    else $error("watchdog reset too short");
  a_wake_on_irq: assert property ($rose(irq_pending) && !pm_out.osc_stop
    |-> ##[1:8] (pm_out.cpu_clk_en || pm_out.sys_rst || pm_out.osc_stop))
    else $error("processor clock not resumed on interrupt");

  c_sys_rst: cover property ($rose(pm_out.sys_rst));
  c_osc_stop: cover property ($rose(pm_out.osc_stop));
  c_irq: cover property ($rose(irq));
endmodule

bind wpr_ctrl wpr_ctrl_asserts #(.WDOG_BITS(WDOG_BITS), .PS_BITS(PS_BITS)) i_wpr_ctrl_asserts (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .reset_pin(reset_pin), .irq_pending(irq_pending),
  .pm_out(pm_out), .init_out(init_out), .irq(irq)
);

// file: test/testbench.sv
// Purpose: self-checking bench of the power and watchdog control block
// Assumes: ahb-lite master in the bench, 20 MHz ref_clk
// Notes:   counter shortened to 4 bits
`timescale 1ns/10ps
module testbench;
  import wpr_pkg::*;
  localparam int WB = 4;
  logic        ref_clk, rst, hsel, hwrite, reset_pin, irq_pending, irq, prev_rst;
  logic        hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wpr_pm_t     pm_out;
  wpr_init_t   init_out;
  int          err_total, tests_run, rst_seen;

  wpr_ctrl #(.WDOG_BITS(WB), .PS_BITS(8)) i_wpr_ctrl (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin(reset_pin),
    .irq_pending(irq_pending), .pm_out(pm_out), .init_out(init_out), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (pm_out.sys_rst === 1'b1 && prev_rst !== 1'b1) rst_seen++;
    prev_rst = pm_out.sys_rst;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin err_total++; end_of_test(); end
    rdat = hrdata;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic wait_sys(input logic v, input int max, output int n);
    n = 0;
    while (pm_out.sys_rst !== v && n < max) begin @(posedge ref_clk); n++; end
    if (n >= max) begin err_total++; end_of_test(); end
  endtask

  task automatic cnt(input int n, output int c, output int p);
    c = 0;
    p = 0;
    repeat (n) begin
      @(negedge ref_clk);
      c += (pm_out.cpu_clk_en === 1'b1);
      p += (pm_out.periph_clk_en === 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset_vals;
    rdc(PWR_CTRL_ADDR, 32'h0000_0010);
    rdc(WDOG_CTRL_ADDR, 32'h0000_0000);
    rdc(IRQ_MASK_ADDR, 32'h0000_0000);
    rdc(32'h0000_0400, 32'h0000_0000);
    chk({16'h0000, init_out}, 32'h0000_ff07);
  endtask

  task automatic s_fields;
    wr(PWR_CTRL_ADDR, 32'h0000_000c);
    rdc(PWR_CTRL_ADDR, 32'h0000_000c);
    wr(PWR_CTRL_ADDR, 32'h0000_0010);
    rdc(PWR_CTRL_ADDR, 32'h0000_0000);
    wr(32'h0000_0400, 32'hffff_ffff);
    rdc(PWR_CTRL_ADDR, 32'h0000_0000);
    wr(WDOG_CTRL_ADDR, 32'h0000_0027);
    rdc(WDOG_CTRL_ADDR, 32'h0000_0027);
    wr(WDOG_CTRL_ADDR, 32'h0000_0040);
    cyc(30);
    rdc(WDOG_CTRL_ADDR, 32'h0000_0000);
    rdc(WDOG_CNT_ADDR, 32'h0000_0000);
  endtask

  task automatic s_timeout;
    logic [2:0] sel [4] = '{3'b000, 3'b010, 3'b001, 3'b011};
    int ps [4] = '{2, 4, 8, 16};
    int n, e;
    for (int i = 0; i < 4; i++) begin
      wr(WDOG_CTRL_ADDR, {24'h00_0000, 5'b1_0000, sel[i]});
      e = 12 * (2 ** WB) * ps[i];
      wait_sys(1'b1, e + 100, n);
      chk((n > e - 40 && n < e + 30) ? 32'(e) : 32'(n), 32'(e));
      wait_sys(1'b0, 100, n);
      rdc(WDOG_CTRL_ADDR, 32'h0000_0000);
      rdc(PWR_CTRL_ADDR, 32'h0000_0000);
      rdc(IRQ_STAT_ADDR, 32'h0000_0001);
    end
  endtask

  task automatic s_irq;
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(IRQ_MASK_ADDR, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0001);
    wr(IRQ_STAT_ADDR, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rdc(IRQ_STAT_ADDR, 32'h0000_0000);
  endtask

  task automatic s_kick;
    int r0;
    r0 = rst_seen;
    wr(WDOG_CTRL_ADDR, 32'h0000_0080);
    repeat (4) begin
      cyc(250);
      wr(WDOG_CTRL_ADDR, 32'h0000_00c0);
    end
    chk(32'(rst_seen), 32'(r0));
    wr(WDOG_CTRL_ADDR, 32'h0000_0000);
  endtask

  task automatic s_pin;
    int r0, n;
    r0 = rst_seen;
    reset_pin <= 1'b1;
    cyc(6);
    reset_pin <= 1'b0;
    cyc(60);
    chk(32'(rst_seen), 32'(r0));
    reset_pin <= 1'b1;
    cyc(60);
    reset_pin <= 1'b0;
    chk(32'(rst_seen), 32'(r0 + 1));
    wait_sys(1'b0, 60, n);
    rdc(IRQ_STAT_ADDR, 32'h0000_0002);
    wr(IRQ_STAT_ADDR, 32'h0000_0002);
  endtask

  task automatic s_idle;
    int c, p;
    wr(PWR_CTRL_ADDR, 32'h0000_0001);
    cyc(2);
    cnt(40, c, p);
    chk(32'(c), 32'h0000_0000);
    chk(32'(p), 32'h0000_0014);
    irq_pending <= 1'b1;
    cyc(10);
    irq_pending <= 1'b0;
    cnt(40, c, p);
    chk(32'(c), 32'h0000_0014);
    rdc(PWR_CTRL_ADDR, 32'h0000_0000);
    rdc(IRQ_STAT_ADDR, 32'h0000_0004);
    wr(IRQ_STAT_ADDR, 32'h0000_0004);
  endtask

  task automatic s_pd;
    logic [31:0] a;
    int n;
    wr(WDOG_CTRL_ADDR, 32'h0000_0087);
    wr(PWR_CTRL_ADDR, 32'h0000_0002);
    cyc(3);
    chk({31'h0000_0000, pm_out.osc_stop}, 32'h0000_0001);
    ahb(1'b0, WDOG_CNT_ADDR, 32'h0000_0000, a);
    cyc(100);
    rdc(WDOG_CNT_ADDR, a);
    wr(PWR_CTRL_ADDR, 32'h0000_0000);
    chk({31'h0000_0000, pm_out.osc_stop}, 32'h0000_0001);
    reset_pin <= 1'b1;
    cyc(60);
    reset_pin <= 1'b0;
    wait_sys(1'b0, 60, n);
    cyc(2);
    chk({31'h0000_0000, pm_out.osc_stop}, 32'h0000_0000);
    rdc(WDOG_CTRL_ADDR, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    reset_pin = 1'b0;
    irq_pending = 1'b0;
    prev_rst = 1'b1;
    err_total = 0;
    tests_run = 0;
    rst_seen = 0;
    cyc(3);
    rst <= 1'b0;
    @(posedge ref_clk);
    s_reset_vals();
    s_fields();
    s_timeout();
    s_irq();
    s_kick();
    s_pin();
    s_idle();
    s_pd();
    end_of_test();
  end
endmodule
